// File: hw/llt_timing.sv
// What this block does
// R1 - scan enable changes on shift clock rise
// R2 - generator and signature enables change on fall
// R3 - programmable extra setup and hold cycles
// R4 - each extra count in own field of one access-loaded register
// R5 - generator and signature enables share counts
// R6 - extra cycles before and after capture
// R7 - defaults: one shift dead, two capture dead
// R8 - defaults: one-cycle setup, one-cycle scan hold
// R9 - segment in path when insertion bit 1
// R10 - lockup stage between access and run logic
// R11 - extra-cycle registers reset to zero
`timescale 1ns/1ns
`default_nettype none
module llt_timing
  import llt_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic hwrite,
  input wire logic [1:0] htrans,
  input wire logic [2:0] hsize,
  input wire logic [DW-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [DW-1:0] hrdata,
  input wire logic ijtag_tck,
  input wire logic ijtag_tdi,
  input wire logic ijtag_sel,
  input wire logic ijtag_shift_en,
  input wire logic ijtag_capture_en,
  input wire logic ijtag_update_en,
  output logic ijtag_tdo,
  output logic shift_clk,
  output logic scan_en,
  output logic decomp_update,
  output logic lfsr_en,
  output logic sig_acc_en
);
  // access pin synchronisers
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] s1_r;
  logic [NPIN-1:0] s2_r;
  logic tck_d_r;

  assign pin_raw = {ijtag_tck, ijtag_tdi, ijtag_sel, ijtag_shift_en,
                    ijtag_capture_en, ijtag_update_en};

  generate
    for (genvar i = 0; i < NPIN; i++) begin : g_sync
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          s1_r[i] <= 1'b0;
          s2_r[i] <= 1'b0;
        end else begin
          s1_r[i] <= pin_raw[i];
          s2_r[i] <= s1_r[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tck_d_r <= 1'b0;
    end else begin
      tck_d_r <= s2_r[PIN_TCK];
    end
  end

  llt_tdr_if tif ();

  assign tif.tck_rise = s2_r[PIN_TCK] & ~tck_d_r;
  assign tif.tck_fall = ~s2_r[PIN_TCK] & tck_d_r;
  assign tif.tdi = s2_r[PIN_TDI];
  assign tif.sel = s2_r[PIN_SEL];
  assign tif.shift_en = s2_r[PIN_SH];
  assign tif.capture_en = s2_r[PIN_CAP];
  assign tif.update_en = s2_r[PIN_UPD];
  assign ijtag_tdo = tif.tdo;

  llt_tdr_seg u_seg (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .bus(tif.seg)
  );

  // run-side state
  llt_state_e st_r;
  llt_state_e st_nxt;
  logic [CTW-1:0] cnt_r;
  logic [CTW-1:0] cnt_nxt;
  logic [PNW-1:0] pdone_r;
  logic [TDRW-1:0] lk_r;
  logic [TDRW-1:0] cfg_r;
  logic [SLW-1:0] shlen_r;
  logic [CPW-1:0] capn_r;
  logic [PNW-1:0] patn_r;
  logic go_r;
  logic abort_r;
  logic [DVW-1:0] dv_r;
  logic ph_r;
  logic sclk_r;
  logic se_r;
  logic upd_r;
  logic pm_r;

  // lockup stage, then snapshot while idle
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      lk_r <= '0; // R11
    end else begin
      lk_r <= tif.cnt; // R10
    end
  end

  wire idle = (st_r == ST_IDLE);
  wire half = (dv_r == DIV_HALF - DVW'(1));
  wire tick_a = half & ph_r;
  wire tick_b = half & ~ph_r;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_r <= '0; // R11
    end else if (tick_a && idle) begin
      cfg_r <= lk_r; // R4
    end
  end

  // per-signal extra setup and hold counts
  wire [CW-1:0] se_su = cfg_r[SE_POS+SU_LSB +: CW]; // R3
  wire [CW-1:0] se_hd = cfg_r[SE_POS+HD_LSB +: CW];
  wire [CW-1:0] up_su = cfg_r[UP_POS+SU_LSB +: CW];
  wire [CW-1:0] up_hd = cfg_r[UP_POS+HD_LSB +: CW];
  wire [CW-1:0] pm_su = cfg_r[PM_POS+SU_LSB +: CW]; // R5
  wire [CW-1:0] pm_hd = cfg_r[PM_POS+HD_LSB +: CW]; // R5

  // ahb-lite slave, zero wait states
  logic wp_r;
  logic [AW-1:0] wa_r;
  logic [DW-1:0] rd_nxt;
  wire [AW-1:0] a = haddr[AW-1:0];
  wire ap_take = hsel & htrans[HTRANS_ACT] & hready;
  wire ap_rd = ap_take & ~hwrite;
  wire wr_ctrl = wp_r & (wa_r == OFS_CTRL);
  wire wr_shlen = wp_r & (wa_r == OFS_SHLEN);
  wire wr_capn = wp_r & (wa_r == OFS_CAPN);
  wire wr_patn = wp_r & (wa_r == OFS_PATN);
  wire go_set = wr_ctrl & hwdata[CTRL_GO];
  wire ab_set = wr_ctrl & hwdata[CTRL_ABORT];
  wire go_take = tick_a & idle & go_r;
  wire [DW-1:0] stat_w = (DW'(pdone_r) << STAT_PD_LSB)
                       | (DW'(st_r) << STAT_ST_LSB)
                       | (DW'(~idle) << STAT_BUSY);
  wire [DW-1:0] ctrl_w = (DW'(go_r) << CTRL_GO)
                       | (DW'(abort_r) << CTRL_ABORT);

  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;

  always_comb begin
    if (a == OFS_CTRL) begin
      rd_nxt = ctrl_w;
    end else if (a == OFS_SHLEN) begin
      rd_nxt = DW'(shlen_r);
    end else if (a == OFS_CAPN) begin
      rd_nxt = DW'(capn_r);
    end else if (a == OFS_PATN) begin
      rd_nxt = DW'(patn_r);
    end else if (a == OFS_STAT) begin
      rd_nxt = stat_w;
    end else if (a == OFS_TIMV) begin
      rd_nxt = DW'(cfg_r);
    end else begin
      rd_nxt = '0;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wp_r <= 1'b0;
      wa_r <= '0;
    end else if (hready) begin
      wp_r <= ap_take & hwrite;
      wa_r <= a;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      hrdata <= '0;
    end else if (ap_rd) begin
      hrdata <= rd_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      shlen_r <= SHLEN_RST;
      capn_r <= CAPN_RST;
      patn_r <= PATN_RST;
    end else begin
      if (wr_shlen) shlen_r <= hwdata[SLW-1:0];
      if (wr_capn) capn_r <= hwdata[CPW-1:0];
      if (wr_patn) patn_r <= hwdata[PNW-1:0];
    end
  end

  // start and abort requests, set wins over clear
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      go_r <= 1'b0;
      abort_r <= 1'b0;
    end else begin
      go_r <= go_set | (go_r & ~go_take);
      abort_r <= ab_set | (abort_r & ~(tick_a & idle));
    end
  end

  // shift clock divider
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dv_r <= '0;
      ph_r <= 1'b0;
    end else if (half) begin
      dv_r <= '0;
      ph_r <= ~ph_r;
    end else begin
      dv_r <= dv_r + DVW'(1);
    end
  end

  // length of the current phase in shift periods
  logic [CTW-1:0] cur_len;
  always_comb begin
    case (st_r)
      ST_UPD: cur_len = DEAD_SHIFT + CTW'(up_su); // R7
      ST_UHLD: cur_len = CTW'(up_hd) + CTW'(pm_su); // R3
      ST_SHFT: cur_len = CTW'(shlen_r);
      ST_PMHD: cur_len = CTW'(pm_hd); // R6
      ST_SEHD: cur_len = DEAD_SE_HOLD + CTW'(se_hd); // R8
      ST_SESU: cur_len = DEAD_SE_SU + CTW'(se_su); // R8
      ST_CAPT: cur_len = CTW'(capn_r) + CTW'(se_hd); // R6
      default: cur_len = DEAD_SHIFT;
    endcase
  end

  wire [CTW-1:0] cnt_inc = cnt_r + CTW'(1);
  wire last = (cnt_inc >= cur_len);
  wire [PNW-1:0] pd_inc = pdone_r + PNW'(1);
  wire all_done = (pd_inc >= patn_r);
  wire uh_any = (up_hd != '0) | (pm_su != '0);
  wire pmh_any = (pm_hd != '0);

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: if (go_r && !abort_r && patn_r != '0) st_nxt = ST_UPD;
      ST_UPD: if (last) st_nxt = uh_any ? ST_UHLD : ST_SHFT;
      ST_UHLD: if (last) st_nxt = ST_SHFT;
      ST_SHFT: if (last) st_nxt = pmh_any ? ST_PMHD : ST_SEHD; // R6
      ST_PMHD: if (last) st_nxt = ST_SEHD;
      ST_SEHD: if (last) st_nxt = ST_SESU; // R7
      ST_SESU: if (last) st_nxt = ST_CAPT; // R6
      ST_CAPT: if (last) st_nxt = all_done ? ST_IDLE : ST_UPD;
      default: st_nxt = ST_IDLE;
    endcase
    if (abort_r) st_nxt = ST_IDLE;
  end

  assign cnt_nxt = (st_nxt != st_r) ? '0 : cnt_inc;

  // output levels for the coming period
  wire pulse_nxt = (st_nxt == ST_SHFT)
                 | ((st_nxt == ST_CAPT) & (cnt_nxt < CTW'(capn_r)));
  wire se_nxt = (st_nxt == ST_UPD) | (st_nxt == ST_UHLD)
              | (st_nxt == ST_SHFT) | (st_nxt == ST_PMHD)
              | (st_nxt == ST_SEHD);
  wire upd_nxt = (st_nxt == ST_UPD);
  wire pm_now = (st_r == ST_SHFT) | (st_r == ST_PMHD)
              | ((st_r == ST_UHLD) & (cnt_r >= CTW'(up_hd)));

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= ST_IDLE;
      cnt_r <= '0;
    end else if (tick_a) begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pdone_r <= '0;
    end else if (go_take) begin
      pdone_r <= '0;
    end else if (tick_a && st_r == ST_CAPT && last) begin
      pdone_r <= pd_inc;
    end
  end

  // rise of the shift period: clock, scan enable, decompressor update
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_r <= 1'b0;
      se_r <= 1'b0;
      upd_r <= 1'b0;
    end else if (tick_a) begin
      sclk_r <= pulse_nxt;
      se_r <= se_nxt; // R1
      upd_r <= upd_nxt; // R3
    end else if (tick_b) begin
      sclk_r <= 1'b0;
    end
  end

  // fall of the shift period: generator and signature enables
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pm_r <= 1'b0;
    end else if (tick_b) begin
      pm_r <= pm_now; // R2
    end
  end

  assign shift_clk = sclk_r;
  assign scan_en = se_r;
  assign decomp_update = upd_r;
  assign lfsr_en = pm_r; // R5
  assign sig_acc_en = pm_r; // R5
endmodule // llt_timing
`default_nettype wire

// File: hw/llt_pkg.sv
`default_nettype none
package llt_pkg;
  // bus
  localparam int DW = 32;
  localparam int AW = 8;
  localparam logic [AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [AW-1:0] OFS_SHLEN = 8'h04;
  localparam logic [AW-1:0] OFS_CAPN = 8'h08;
  localparam logic [AW-1:0] OFS_PATN = 8'h0c;
  localparam logic [AW-1:0] OFS_STAT = 8'h10;
  localparam logic [AW-1:0] OFS_TIMV = 8'h14;
  localparam int CTRL_GO = 0;
  localparam int CTRL_ABORT = 1;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ST_LSB = 1;
  localparam int STAT_PD_LSB = 16;
  localparam int HTRANS_ACT = 1;
  localparam logic HRESP_OKAY = 1'b0;
  // run length fields
  localparam int SLW = 12;
  localparam int CPW = 4;
  localparam int PNW = 16;
  localparam int CTW = 13;
  localparam logic [SLW-1:0] SHLEN_RST = 12'h010;
  localparam logic [CPW-1:0] CAPN_RST = 4'h1;
  localparam logic [PNW-1:0] PATN_RST = 16'h0001;
  // extra-cycle segment layout
  localparam int CW = 4;
  localparam int TDRW = 24;
  localparam int SU_LSB = 0;
  localparam int HD_LSB = 4;
  localparam int SE_POS = 0;
  localparam int UP_POS = 8;
  localparam int PM_POS = 16;
  // fixed dead cycles
  localparam logic [CTW-1:0] DEAD_SHIFT = 13'h0001;
  localparam logic [CTW-1:0] DEAD_SE_HOLD = 13'h0001;
  localparam logic [CTW-1:0] DEAD_SE_SU = 13'h0001;
  // shift clock divider, core cycles per half period
  localparam int DVW = 4;
  localparam logic [DVW-1:0] DIV_HALF = 4'h2;
  // synchronised access pins
  localparam int NPIN = 6;
  localparam int PIN_TCK = 5;
  localparam int PIN_TDI = 4;
  localparam int PIN_SEL = 3;
  localparam int PIN_SH = 2;
  localparam int PIN_CAP = 1;
  localparam int PIN_UPD = 0;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_UPD = 3'b001,
    ST_UHLD = 3'b011,
    ST_SHFT = 3'b010,
    ST_PMHD = 3'b110,
    ST_SEHD = 3'b111,
    ST_SESU = 3'b101,
    ST_CAPT = 3'b100
  } llt_state_e;
endpackage
`default_nettype wire

// File: hw/llt_tdr_if.sv
`timescale 1ns/1ns
`default_nettype none
interface llt_tdr_if;
  import llt_pkg::*;
  logic tck_rise;
  logic tck_fall;
  logic tdi;
  logic sel;
  logic shift_en;
  logic capture_en;
  logic update_en;
  logic tdo;
  logic [TDRW-1:0] cnt;
  modport seg (
    input tck_rise, tck_fall, tdi, sel, shift_en, capture_en, update_en,
    output tdo, cnt
  );
  modport ctl (
    output tck_rise, tck_fall, tdi, sel, shift_en, capture_en, update_en,
    input tdo, cnt
  );
endinterface
`default_nettype wire

// File: hw/llt_tdr_seg.sv
`timescale 1ns/1ns
`default_nettype none
module llt_tdr_seg
  import llt_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  llt_tdr_if.seg bus
);
  logic sib_r;
  logic sibu_r;
  logic tdo_r;
  logic [TDRW-1:0] sr_r;
  logic [TDRW-1:0] upd_r;
  wire step = bus.tck_rise & bus.sel;
  wire do_cap = step & bus.capture_en;
  wire do_sh = step & bus.shift_en;
  wire do_upd = step & bus.update_en;
  wire seg_upd = do_upd & sibu_r;
  wire sib_in = sibu_r ? sr_r[0] : bus.tdi;

  // segment shift stage, in the path only while the insertion bit is 1
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sr_r <= '0;
    end else if (do_cap && sibu_r) begin
      sr_r <= upd_r;
    end else if (do_sh && sibu_r) begin // R9
      sr_r <= {bus.tdi, sr_r[TDRW-1:1]}; // R4
    end
  end

  // insertion bit shift stage, tck rise
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sib_r <= 1'b0;
    end else if (do_cap) begin
      sib_r <= sibu_r;
    end else if (do_sh) begin
      sib_r <= sib_in; // R9
    end
  end

  // insertion bit update stage, path length fixed for a whole scan
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sibu_r <= 1'b0;
    end else if (do_upd) begin
      sibu_r <= sib_r; // R9
    end
  end

  // update stage, zero after reset
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      upd_r <= '0; // R11
    end else if (seg_upd) begin
      upd_r <= sr_r; // R4
    end
  end

  // tdo moves on tck fall
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tdo_r <= 1'b0;
    end else if (bus.tck_fall) begin
      tdo_r <= sib_r; // R10
    end
  end

  assign bus.tdo = tdo_r;
  assign bus.cnt = upd_r;
endmodule // llt_tdr_seg
`default_nettype wire

// File: test/llt_timing_checker.sv
`timescale 1ns/1ns
`default_nettype none
module llt_timing_checker (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic shift_clk,
  input wire logic scan_en,
  input wire logic decomp_update,
  input wire logic lfsr_en,
  input wire logic sig_acc_en
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  property p_se_edge;
    $changed(scan_en) |-> !shift_clk || $rose(shift_clk);
  endproperty
  a_se_edge: assert property (p_se_edge)
    else $error("scan enable moved off period start");
  property p_clk_hi2;
    $rose(shift_clk) |=> shift_clk ##1 !shift_clk;
  endproperty
  a_clk_hi2: assert property (p_clk_hi2)
    else $error("shift clock high time wrong");
  property p_en_edge;
    $changed(lfsr_en) |-> !shift_clk && $stable(scan_en);
  endproperty
  a_en_edge: assert property (p_en_edge)
    else $error("generator enable moved off mid period");
  property p_en_same;
    lfsr_en == sig_acc_en;
  endproperty
  a_en_same: assert property (p_en_same)
    else $error("generator and signature enables differ");
  property p_upd_se;
    decomp_update |-> scan_en;
  endproperty
  a_upd_se: assert property (p_upd_se)
    else $error("update without scan enable");
  property p_se_low8;
    $fell(scan_en) |-> !scan_en [*8];
  endproperty
  a_se_low8: assert property (p_se_low8)
    else $error("capture pause too short");
  property p_se_fall;
    $fell(scan_en) |-> !lfsr_en && !decomp_update;
  endproperty
  a_se_fall: assert property (p_se_fall)
    else $error("scan enable fell before enables");
  property p_en_off;
    $fell(lfsr_en) |-> scan_en [*2];
  endproperty
  a_en_off: assert property (p_en_off)
    else $error("scan enable hold missing");
endmodule // llt_timing_checker
`default_nettype wire

// File: test/llt_ijtag_far.sv
`timescale 1ns/1ns
`default_nettype none
module llt_ijtag_far (
  input wire logic core_clk,
  output logic tck,
  output logic tdi,
  output logic sel,
  output logic shift_en,
  output logic capture_en,
  output logic update_en,
  input wire logic tdo
);
  logic tdo_seen;
  initial {tck, tdi, sel, shift_en, capture_en, update_en} = 6'h00;
  // one access clock period, four core cycles a half
  task automatic pulse();
    repeat (4) @(posedge core_clk);
    tck <= 1'b1;
    repeat (4) @(posedge core_clk);
    tck <= 1'b0;
    tdo_seen = tdo;
  endtask
  // capture, shift n bits first bit nearest tdo, update
  task automatic scan(input logic [24:0] v, input int n);
    sel <= 1'b1;
    capture_en <= 1'b1;
    pulse();
    capture_en <= 1'b0;
    shift_en <= 1'b1;
    for (int i = 0; i < n; i++) begin
      tdi <= v[i];
      pulse();
    end
    shift_en <= 1'b0;
    update_en <= 1'b1;
    pulse();
    update_en <= 1'b0;
    sel <= 1'b0;
    pulse();
  endtask
endmodule // llt_ijtag_far
`default_nettype wire

// File: test/test_lbist_load_unload_timing.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, a) begin checks_done++; if ((a) !== (e)) begin \
  err_count++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, a); end end
module test_lbist_load_unload_timing;
  import llt_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [DW-1:0] hwdata = 32'h0;
  logic hready, hresp, ijtag_tdo, shift_clk, scan_en;
  logic decomp_update, lfsr_en, sig_acc_en;
  logic tck, tdi, sel, sh, cap, upd;
  logic [DW-1:0] hrdata, rv;
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int lo, np;
  always #2 core_clk = ~core_clk;
  llt_timing i_dut (.core_clk(core_clk), .reset_n(reset_n), .hsel(hsel),
    .haddr(haddr), .hwrite(hwrite), .htrans(htrans), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .ijtag_tck(tck), .ijtag_tdi(tdi), .ijtag_sel(sel),
    .ijtag_shift_en(sh), .ijtag_capture_en(cap), .ijtag_update_en(upd),
    .ijtag_tdo(ijtag_tdo), .shift_clk(shift_clk), .scan_en(scan_en),
    .decomp_update(decomp_update), .lfsr_en(lfsr_en),
    .sig_acc_en(sig_acc_en));
  llt_ijtag_far i_far (.core_clk(core_clk), .tck(tck), .tdi(tdi),
    .sel(sel), .shift_en(sh), .capture_en(cap), .update_en(upd),
    .tdo(ijtag_tdo));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic bus(input logic [7:0] a, input logic w,
      input logic [DW-1:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge core_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge core_clk); while (hready !== 1'b1);
    rv = hrdata;
  endtask
  task automatic t_reset();
    bus(OFS_TIMV, 1'b1, 32'hffffff);
    bus(OFS_TIMV, 1'b0, 32'h0);
    `CHK("timv", 32'h0, rv)
    bus(8'h40, 1'b1, 32'h5);
    bus(8'h40, 1'b0, 32'h0);
    `CHK("unmapped", 32'h0, rv)
    $display("test reset done");
  endtask
  task automatic t_prog();
    i_far.scan(25'h1, 1);
    `CHK("tdo open", 1'b1, i_far.tdo_seen)
    i_far.scan({24'h110012, 1'b1}, 25);
    bus(OFS_TIMV, 1'b0, 32'h0);
    `CHK("timv load", 32'h110012, rv)
    i_far.scan({24'h110012, 1'b0}, 25);
    `CHK("tdo closed", 1'b0, i_far.tdo_seen)
    i_far.scan(25'h0fffffe, 25);
    bus(OFS_TIMV, 1'b0, 32'h0);
    `CHK("timv bypass", 32'h110012, rv)
    $display("test program done");
  endtask
  task automatic run_chk(input int elo, input string nm);
    int r;
    logic ps, pc;
    bus(OFS_CTRL, 1'b1, 32'h1 << CTRL_GO);
    lo = 0;
    np = 0;
    r = 0;
    ps = scan_en;
    pc = shift_clk;
    for (int n = 0; n < 3000 && r < 2; n++) begin
      @(negedge core_clk);
      if (scan_en && !ps) r++;
      if (r == 1 && shift_clk && !pc) np++;
      if (r == 1 && !scan_en) lo++;
      ps = scan_en;
      pc = shift_clk;
    end
    `CHK("se low", elo, lo)
    `CHK("pulses", int'(SHLEN_RST) + int'(CAPN_RST), np)
    for (int i = 0; i < 100; i++) begin
      bus(OFS_STAT, 1'b0, 32'h0);
      if (rv[STAT_BUSY] === 1'b0) break;
    end
    `CHK("busy", 1'b0, rv[STAT_BUSY])
    $display("test %s done", nm);
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    t_reset();
    bus(OFS_PATN, 1'b1, 32'h2);
    run_chk(4 * (1 + int'(CAPN_RST)), "default");
    t_prog();
    run_chk(4 * (4 + int'(CAPN_RST)), "extra");
    complete_run();
  end
endmodule // test_lbist_load_unload_timing
bind llt_timing llt_timing_checker u_chk (.core_clk(core_clk),
  .reset_n(reset_n), .shift_clk(shift_clk), .scan_en(scan_en),
  .decomp_update(decomp_update), .lfsr_en(lfsr_en),
  .sig_acc_en(sig_acc_en));
`default_nettype wire
